/* File: verilog/light_prox_sensor_control.sv */
// Register file, measurement sequencer and interrupt logic of the light and proximity sensor.
`timescale 1ns/1ps
`include "lps_map.svh"

// Notes on behaviour
// RQ1 - Proximity interrupts are raised only while the proximity mask bit is one.
// RQ2 - Light interrupts are raised only while the light mask bit is one.
// RQ3 - Enable bit 3 turns the wait phase between cycles on or off.
// RQ4 - Enable bit 2 turns the proximity measurement on or off.
// RQ5 - Enable bit 1 turns the two-channel light converter on or off.
// RQ6 - Enable bit 0 runs the oscillator that paces all timers.
// RQ7 - No measurement starts until one 2.72 ms step after power-on.
// RQ8 - Light integration lasts 256 minus code steps of 2.72 ms.
// RQ9 - Light integration code resets to zero, the longest integration.
// RQ10 - Proximity integration lasts 256 minus code steps of 2.72 ms.
// RQ11 - Host should program proximity integration code to one step.
// RQ12 - Wait lasts 256 minus code steps; code zero gives 256 steps.
// RQ13 - Wait stretch makes every wait twelve times longer.
// RQ14 - Host should program wait time before enabling measurements.
// RQ15 - Light result outside the light thresholds flags a light interrupt.
// RQ16 - Light thresholds are 16-bit byte pairs at 0x04..0x07, low byte first.
// RQ17 - Proximity result outside the proximity thresholds flags a proximity interrupt.
// RQ18 - Proximity thresholds are 16-bit byte pairs at 0x08..0x0B.
// RQ19 - Special commands 5, 6, 7 clear proximity, light or both pending interrupts.
// RQ20 - Persistence zero interrupts every cycle; otherwise needs consecutive out-of-range results.
// RQ21 - Wait stretch lives in bit 1 of the configuration register.
// RQ22 - Full 16-bit compares; interrupt pin holds until the host clears it.
module light_prox_sensor_control #(
  parameter int STEP_CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        cmd_wr,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [7:0]  wr_byte,
  output logic      [7:0]  rd_data,
  input  wire logic [15:0] light_channel0_result,
  input  wire logic        light_valid,
  input  wire logic [15:0] prox_result,
  input  wire logic        prox_valid,
  output logic             osc_run,
  output logic             light_integrating,
  output logic             prox_integrating,
  output logic             waiting,
  output logic             irq_out,
  output logic             irq_oe
);

  // --------------------------------------------------------------------------
  // Register file and command decode
  // --------------------------------------------------------------------------
  lps_pkg::enable_s      en_q, en_d;
  lps_pkg::persistence_s pers_q, pers_d;
  lps_pkg::command_s     cmd_in;
  logic [7:0]            light_integ_code_q, light_integ_code_d;
  logic [7:0]            prox_integ_code_q, prox_integ_code_d;
  logic [7:0]            wait_code_q, wait_code_d;
  logic [7:0]            config_q, config_d;
  logic [7:0]            thresh_q [8];
  logic [7:0]            thresh_d [8];
  logic [4:0]            addr_q, addr_d;
  logic [1:0]            kind_q, kind_d;
  logic [7:0]            rd_data_q, rd_data_d;
  logic [7:0]            rd_mux;
  logic                  clr_prox, clr_light;
  logic                  prox_pend_q, prox_pend_d;
  logic                  light_pend_q, light_pend_d;

  assign cmd_in  = wr_byte;
  assign rd_data = rd_data_q;

  // Threshold bytes are kept in one array; a pair forms one 16-bit value.
  function automatic logic [15:0] thresh16(input logic [4:0] lo_off);
    logic [2:0] i;
    i = 3'(lo_off - `REG_LIGHT_LOW_LO);
    thresh16 = {thresh_q[i + 3'h1], thresh_q[i]};
  endfunction

  always_comb begin
    rd_mux = 8'h00;
    if (addr_q == `REG_FUNCTION_ENABLE) begin
      rd_mux = en_q;
    end else if (addr_q == `REG_LIGHT_INTEG_TIME) begin
      rd_mux = light_integ_code_q;
    end else if (addr_q == `REG_PROX_INTEG_TIME) begin
      rd_mux = prox_integ_code_q;
    end else if (addr_q == `REG_WAIT_TIME) begin
      rd_mux = wait_code_q;
    end else if (addr_q >= `REG_LIGHT_LOW_LO && addr_q <= `REG_THRESH_LAST) begin
      rd_mux = thresh_q[3'(addr_q - `REG_LIGHT_LOW_LO)];
    end else if (addr_q == `REG_PERSISTENCE) begin
      rd_mux = pers_q;
    end else if (addr_q == `REG_CONFIG) begin
      rd_mux = config_q;
    end else if (addr_q == `REG_STATUS) begin
      rd_mux[`STATUS_PROX_PEND]  = prox_pend_q;
      rd_mux[`STATUS_LIGHT_PEND] = light_pend_q;
    end
  end

  always_comb begin
    en_d               = en_q;
    pers_d             = pers_q;
    light_integ_code_d = light_integ_code_q;
    prox_integ_code_d  = prox_integ_code_q;
    wait_code_d        = wait_code_q;
    config_d           = config_q;
    thresh_d           = thresh_q;
    addr_d             = addr_q;
    kind_d             = kind_q;
    rd_data_d          = rd_data_q;
    clr_prox           = 1'b0;
    clr_light          = 1'b0;
    if (cmd_wr && cmd_in.sel) begin
      if (cmd_in.kind == `CMD_KIND_SPECIAL) begin
        // Clears are one-cycle strobes, so nothing has to be written back.
        clr_prox  = (cmd_in.addr == `SF_PROX_CLEAR) || (cmd_in.addr == `SF_BOTH_CLEAR);  // see RQ19
        clr_light = (cmd_in.addr == `SF_LIGHT_CLEAR) || (cmd_in.addr == `SF_BOTH_CLEAR); // see RQ19
      end else begin
        kind_d = cmd_in.kind;
        addr_d = cmd_in.addr;
      end
    end else if (data_wr) begin
      if (addr_q == `REG_FUNCTION_ENABLE) begin
        en_d = wr_byte;
      end else if (addr_q == `REG_LIGHT_INTEG_TIME) begin
        light_integ_code_d = wr_byte;
      end else if (addr_q == `REG_PROX_INTEG_TIME) begin
        prox_integ_code_d = wr_byte;
      end else if (addr_q == `REG_WAIT_TIME) begin
        wait_code_d = wr_byte;
      end else if (addr_q >= `REG_LIGHT_LOW_LO && addr_q <= `REG_THRESH_LAST) begin
        thresh_d[3'(addr_q - `REG_LIGHT_LOW_LO)] = wr_byte; // see RQ16, RQ18
      end else if (addr_q == `REG_PERSISTENCE) begin
        pers_d = wr_byte;
      end else if (addr_q == `REG_CONFIG) begin
        config_d = wr_byte;
      end
      if (kind_q == `CMD_KIND_AUTO_INC) begin
        addr_d = addr_q + 5'h01;
      end
    end else if (data_rd) begin
      rd_data_d = rd_mux;
      if (kind_q == `CMD_KIND_AUTO_INC) begin
        addr_d = addr_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      en_q               <= `RST_ENABLE;
      pers_q             <= `RST_PERSISTENCE;
      light_integ_code_q <= `RST_LIGHT_INTEG; // see RQ9
      prox_integ_code_q  <= `RST_PROX_INTEG;
      wait_code_q        <= `RST_WAIT_TIME;
      config_q           <= `RST_CONFIG;
      thresh_q           <= '{default: `RST_THRESH};
      addr_q             <= 5'h00;
      kind_q             <= `CMD_KIND_REPEAT;
      rd_data_q          <= 8'h00;
    end else begin
      en_q               <= en_d;
      pers_q             <= pers_d;
      light_integ_code_q <= light_integ_code_d;
      prox_integ_code_q  <= prox_integ_code_d;
      wait_code_q        <= wait_code_d;
      config_q           <= config_d;
      thresh_q           <= thresh_d;
      addr_q             <= addr_d;
      kind_q             <= kind_d;
      rd_data_q          <= rd_data_d;
    end
  end

  // --------------------------------------------------------------------------
  // Measurement sequencer
  // --------------------------------------------------------------------------
  lps_pkg::seq_e   state_q, state_d;
  lps_pkg::phase_s phase_q, phase_d;
  logic [11:0]     steps_q, steps_d;
  logic            step;

  // The select cycle restarts the count, so every phase begins on a fresh step.
  // A tick already rolls the count over, and the step decision must not feed back on itself.
  step_timer #(
    .CYCLES (STEP_CYCLES)
  ) u_step (
    .clk     (clk),
    .rstn    (rstn),
    .run     (state_q != lps_pkg::SEQ_IDLE), // see RQ6
    .restart (state_q == lps_pkg::SEQ_SELECT),
    .tick    (step)
  );

  function automatic lps_pkg::seq_e next_phase(input lps_pkg::seq_e from);
    next_phase = lps_pkg::SEQ_SELECT;
    case (from)
      lps_pkg::SEQ_SELECT: begin
        if (en_q.prox_function_on) begin
          next_phase = lps_pkg::SEQ_PROX;  // see RQ4
        end else if (en_q.light_function_on) begin
          next_phase = lps_pkg::SEQ_LIGHT; // see RQ5
        end
      end
      lps_pkg::SEQ_PROX: begin
        if (en_q.light_function_on) begin
          next_phase = lps_pkg::SEQ_LIGHT; // see RQ5
        end else if (en_q.wait_on) begin
          next_phase = lps_pkg::SEQ_WAIT;  // see RQ3
        end
      end
      lps_pkg::SEQ_LIGHT: begin
        if (en_q.wait_on) begin
          next_phase = lps_pkg::SEQ_WAIT;  // see RQ3
        end
      end
      default: next_phase = lps_pkg::SEQ_SELECT;
    endcase
  endfunction

  function automatic logic [11:0] phase_steps(input lps_pkg::seq_e ph);
    phase_steps = 12'h001;
    case (ph)
      lps_pkg::SEQ_PROX:  phase_steps = `STEP_SPAN - {4'h0, prox_integ_code_q};  // see RQ10
      lps_pkg::SEQ_LIGHT: phase_steps = `STEP_SPAN - {4'h0, light_integ_code_q}; // see RQ8
      lps_pkg::SEQ_WAIT: begin
        phase_steps = `STEP_SPAN - {4'h0, wait_code_q}; // see RQ12
        if (config_q[`CONFIG_WAIT_STRETCH]) begin
          phase_steps = phase_steps * `WAIT_STRETCH_FACTOR; // see RQ13, RQ21
        end
      end
      default: phase_steps = 12'h001;
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    steps_d = steps_q;
    if (!en_q.oscillator_power_on) begin
      state_d = lps_pkg::SEQ_IDLE; // see RQ6
    end else begin
      case (state_q)
        lps_pkg::SEQ_IDLE: begin
          // One full step of warm-up before any conversion may begin.
          state_d = lps_pkg::SEQ_WARM; // see RQ7
          steps_d = 12'h001;
        end
        lps_pkg::SEQ_SELECT: begin
          state_d = next_phase(state_q);
          steps_d = phase_steps(state_d);
        end
        default: begin
          if (step) begin
            if (steps_q > 12'h001) begin
              steps_d = steps_q - 12'h001;
            end else begin
              state_d = next_phase(state_q);
              steps_d = phase_steps(state_d);
            end
          end
        end
      endcase
    end
    phase_d.osc_run           = (state_d != lps_pkg::SEQ_IDLE);
    phase_d.light_integrating = (state_d == lps_pkg::SEQ_LIGHT);
    phase_d.prox_integrating  = (state_d == lps_pkg::SEQ_PROX);
    phase_d.waiting           = (state_d == lps_pkg::SEQ_WAIT);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= lps_pkg::SEQ_IDLE;
      steps_q <= 12'h000;
      phase_q <= '0;
    end else begin
      state_q <= state_d;
      steps_q <= steps_d;
      phase_q <= phase_d;
    end
  end

  assign osc_run           = phase_q.osc_run;
  assign light_integrating = phase_q.light_integrating;
  assign prox_integrating  = phase_q.prox_integrating;
  assign waiting           = phase_q.waiting;

  // --------------------------------------------------------------------------
  // Threshold compare, persistence and interrupt pin
  // --------------------------------------------------------------------------
  logic [3:0] prox_cnt_q, prox_cnt_d;
  logic [5:0] light_cnt_q, light_cnt_d;
  logic [5:0] light_need;
  logic       prox_out, light_out, prox_set, light_set;
  logic       irq_oe_q;

  always_comb begin
    light_need = {2'h0, pers_q.light_persistence};
    if (pers_q.light_persistence > `APERS_DIRECT_MAX) begin
      light_need = {2'h0, pers_q.light_persistence - `APERS_DIRECT_MAX} * `APERS_STEP;
    end
  end

  assign prox_out  = (prox_result < thresh16(`REG_PROX_LOW_LO))
                  || (prox_result > thresh16(`REG_PROX_HIGH_LO));             // see RQ17, RQ22
  assign light_out = (light_channel0_result < thresh16(`REG_LIGHT_LOW_LO))
                  || (light_channel0_result > thresh16(`REG_LIGHT_HIGH_LO));  // see RQ15, RQ22

  always_comb begin
    prox_cnt_d  = prox_cnt_q;
    light_cnt_d = light_cnt_q;
    prox_set    = 1'b0;
    light_set   = 1'b0;
    if (prox_valid && en_q.prox_function_on) begin
      prox_cnt_d = prox_out ? ((prox_cnt_q == 4'hf) ? prox_cnt_q : prox_cnt_q + 4'h1) : 4'h0;
      prox_set   = (pers_q.prox_persistence == 4'h0)
                || (prox_out && ({1'b0, prox_cnt_q} + 5'h01 >= {1'b0, pers_q.prox_persistence})); // see RQ20
    end
    if (light_valid && en_q.light_function_on) begin
      light_cnt_d = light_out ? ((light_cnt_q == 6'h3f) ? light_cnt_q : light_cnt_q + 6'h01)
                              : 6'h00;
      light_set   = (light_need == 6'h00)
                 || (light_out && ({1'b0, light_cnt_q} + 7'h01 >= {1'b0, light_need}));
    end
    // A new event in the clearing cycle wins over the clear.
    prox_pend_d  = (prox_set && en_q.prox_irq_mask) ? 1'b1
                 : (clr_prox ? 1'b0 : prox_pend_q);                // see RQ1, RQ22
    light_pend_d = (light_set && en_q.light_irq_mask) ? 1'b1
                 : (clr_light ? 1'b0 : light_pend_q);              // see RQ2, RQ22
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      prox_cnt_q   <= 4'h0;
      light_cnt_q  <= 6'h00;
      prox_pend_q  <= 1'b0;
      light_pend_q <= 1'b0;
      irq_oe_q     <= 1'b0;
    end else begin
      prox_cnt_q   <= prox_cnt_d;
      light_cnt_q  <= light_cnt_d;
      prox_pend_q  <= prox_pend_d;
      light_pend_q <= light_pend_d;
      irq_oe_q     <= prox_pend_d || light_pend_d; // see RQ22
    end
  end

  // The pin is open drain: it only ever pulls low.
  assign irq_out = 1'b0;
  assign irq_oe  = irq_oe_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic [31:0] on_cnt_q;

  always_ff @(posedge clk) begin
    if (!rstn || !en_q.oscillator_power_on) begin
      on_cnt_q <= 32'h0;
    end else if (on_cnt_q != 32'hffffffff) begin
      on_cnt_q <= on_cnt_q + 32'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_prox_mask_gate:  assert property ($rose(prox_pend_q) |-> $past(en_q.prox_irq_mask)) // see RQ1
    else $error("proximity interrupt raised while masked");
  a_light_mask_gate: assert property ($rose(light_pend_q) |-> $past(en_q.light_irq_mask)) // see RQ2
    else $error("light interrupt raised while masked");
  a_wait_needs_en:   assert property ($rose(waiting) |-> $past(en_q.wait_on)) // see RQ3
    else $error("wait phase entered without wait enable");
  a_prox_needs_en:   assert property ($rose(prox_integrating) |-> $past(en_q.prox_function_on)) // see RQ4
    else $error("proximity phase entered while disabled");
  a_light_needs_en:  assert property ($rose(light_integrating) |-> $past(en_q.light_function_on)) // see RQ5
    else $error("light phase entered while disabled");
  a_osc_stops_off:   assert property (!en_q.oscillator_power_on |=> !osc_run) // see RQ6
    else $error("oscillator runs after power-off");
  a_warm_holdoff:    assert property (($rose(prox_integrating) // see RQ7
                       || $rose(light_integrating)) |-> on_cnt_q > 32'(STEP_CYCLES))
    else $error("measurement began inside the warm-up step");
  a_light_steps:     assert property ($rose(light_integrating) |-> // see RQ8
                       steps_q == `STEP_SPAN - {4'h0, light_integ_code_q})
    else $error("wrong light integration step count");
  a_prox_steps:      assert property ($rose(prox_integrating) |-> // see RQ10
                       steps_q == `STEP_SPAN - {4'h0, prox_integ_code_q})
    else $error("wrong proximity integration step count");
  a_wait_steps:      assert property ($rose(waiting) |-> steps_q == // see RQ12, RQ13
                       ((`STEP_SPAN - {4'h0, wait_code_q}) *
                        (config_q[`CONFIG_WAIT_STRETCH] ? `WAIT_STRETCH_FACTOR : 12'h001)))
    else $error("wrong wait step count");
  a_clear_works:     assert property (clr_prox && !prox_set |=> !prox_pend_q) // see RQ19
    else $error("proximity clear did not clear");
  a_pin_holds:       assert property ($fell(irq_oe) |-> $past(clr_prox || clr_light)) // see RQ22
    else $error("interrupt pin released without a clear");

  c_prox_irq:  cover property ($rose(prox_pend_q));
  c_light_irq: cover property ($rose(light_pend_q));
  c_wait:      cover property ($rose(waiting));
  c_clear:     cover property (clr_light && light_pend_q);

endmodule

/* File: inc/lps_map.svh */
// Register offsets, field positions, reset values and timing figures of the sensor control.
`ifndef LPS_MAP_SVH
`define LPS_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_FUNCTION_ENABLE    5'h00
`define REG_LIGHT_INTEG_TIME   5'h01
`define REG_PROX_INTEG_TIME    5'h02
`define REG_WAIT_TIME          5'h03
`define REG_LIGHT_LOW_LO       5'h04
`define REG_LIGHT_HIGH_LO      5'h06
`define REG_PROX_LOW_LO        5'h08
`define REG_PROX_HIGH_LO       5'h0a
`define REG_THRESH_LAST        5'h0b
`define REG_PERSISTENCE        5'h0c
`define REG_CONFIG             5'h0d
`define REG_STATUS             5'h13

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CMD_SELECT_BIT         7
`define CMD_KIND_REPEAT        2'h0
`define CMD_KIND_AUTO_INC      2'h1
`define CMD_KIND_SPECIAL       2'h3
`define SF_PROX_CLEAR          5'h05
`define SF_LIGHT_CLEAR         5'h06
`define SF_BOTH_CLEAR          5'h07
`define CONFIG_WAIT_STRETCH    1
`define STATUS_PROX_PEND       5
`define STATUS_LIGHT_PEND      4
`define RST_ENABLE             8'h00
`define RST_LIGHT_INTEG        8'h00
`define RST_PROX_INTEG         8'h00
`define RST_WAIT_TIME          8'hff
`define RST_THRESH             8'h00
`define RST_PERSISTENCE        8'h00
`define RST_CONFIG             8'h00
`define APERS_DIRECT_MAX       4'h3
`define APERS_STEP             6'h05

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS          10
`define STEP_TIME_NS           2720000
`define STEP_SPAN              12'h100
`define WAIT_STRETCH_FACTOR    12'h00c

`endif

/* File: inc/lps_pkg.sv */
// Types shared by the light and proximity sensor control.
package lps_pkg;

  typedef struct packed {
    logic [1:0] reserved;
    logic       prox_irq_mask;
    logic       light_irq_mask;
    logic       wait_on;
    logic       prox_function_on;
    logic       light_function_on;
    logic       oscillator_power_on;
  } enable_s;

  typedef struct packed {
    logic [3:0] prox_persistence;
    logic [3:0] light_persistence;
  } persistence_s;

  typedef struct packed {
    logic       sel;
    logic [1:0] kind;
    logic [4:0] addr;
  } command_s;

  typedef struct packed {
    logic osc_run;
    logic light_integrating;
    logic prox_integrating;
    logic waiting;
  } phase_s;

  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_WARM,
    SEQ_SELECT,
    SEQ_PROX,
    SEQ_LIGHT,
    SEQ_WAIT
  } seq_e;

endpackage

/* File: verilog/step_timer.sv */
// Base step tick generator that paces the measurement sequence.
`timescale 1ns/1ps
`include "lps_map.svh"

module step_timer #(
  parameter int CYCLES = `STEP_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic restart,
  output logic      tick
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         last;

  assign last = (cnt_q == W'(CYCLES - 1));
  assign tick = run && !restart && last;

  always_comb begin
    cnt_d = cnt_q + 1'b1;
    if (!run || restart || last) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: dv/host_model.sv */
// Host processor model that drives the register port of the sensor control.
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  output logic            cmd_wr,
  output logic            data_wr,
  output logic            data_rd,
  output logic [7:0]      wr_byte,
  input  wire logic [7:0] rd_data
);
  initial begin
    {cmd_wr, data_wr, data_rd} = 3'h0;
    wr_byte = 8'h00;
  end

  // One request is held across one rising edge, then the idle bus shows the inverse byte.
  task automatic xfer(input logic [2:0] kind, input logic [7:0] b, output logic [7:0] d);
    @(posedge clk);
    #1;
    {cmd_wr, data_wr, data_rd} = kind;
    wr_byte = b;
    @(posedge clk);
    #1;
    {cmd_wr, data_wr, data_rd} = 3'h0;
    wr_byte = ~b;
    d = rd_data;
  endtask
endmodule

/* File: dv/light_prox_sensor_control_tb_top.sv */
// Self-checking testbench of the light and proximity sensor control.
`timescale 1ns/1ps
module light_prox_sensor_control_tb_top;
  localparam int S = 8;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cmd_wr;
  logic        data_wr;
  logic        data_rd;
  logic [7:0]  wr_byte;
  logic [7:0]  rd_data;
  logic [15:0] lres = 16'h0000;
  logic        lval = 1'b0;
  logic [15:0] pres = 16'h0000;
  logic        pval = 1'b0;
  logic [3:0]  ph;
  logic        irq_out;
  logic        irq_oe;
  int          err_count = 0;
  int          comparisons = 0;
  int          n;
  logic [7:0]  d;

  always #5 clk = ~clk;

  light_prox_sensor_control #(.STEP_CYCLES(S)) u_light_prox_sensor_control (
    .clk(clk), .rstn(rstn), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd),
    .wr_byte(wr_byte), .rd_data(rd_data), .light_channel0_result(lres), .light_valid(lval),
    .prox_result(pres), .prox_valid(pval), .osc_run(ph[3]), .light_integrating(ph[2]),
    .prox_integrating(ph[1]), .waiting(ph[0]), .irq_out(irq_out), .irq_oe(irq_oe)
  );

  host_model u_host_model (
    .clk(clk), .cmd_wr(cmd_wr), .data_wr(data_wr), .data_rd(data_rd),
    .wr_byte(wr_byte), .rd_data(rd_data)
  );

  // --------------------------------------------------------------------------
  // Access and check tasks
  // --------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd(input logic [7:0] b);
    u_host_model.xfer(3'h4, b, d);
  endtask

  task automatic regw(input logic [4:0] a, input logic [7:0] v);
    cmd({3'h4, a});
    u_host_model.xfer(3'h2, v, d);
  endtask

  task automatic regr(input logic [4:0] a, input logic [7:0] exp);
    cmd({3'h4, a});
    u_host_model.xfer(3'h1, 8'h00, d);
    check($sformatf("reg %h", a), {8'h00, exp}, {8'h00, d});
  endtask

  // Presents one light or proximity result and looks at the pin one cycle later.
  task automatic ev(input logic prox, input logic [15:0] v, input logic exp);
    @(posedge clk);
    #1;
    {lres, pres} = {v, v};
    {pval, lval} = {prox, !prox};
    @(posedge clk);
    #1;
    {pval, lval} = 2'h0;
    {lres, pres} = ~{v, v};
    check("irq_oe", {15'h0, exp}, {15'h0, irq_oe});
  endtask

  task automatic wait_for(input int b, input logic lvl);
    n = 0;
    while (ph[b] !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 4000) begin
        err_count++;
        $display("[ERR] phase %0d expected %b seen %b", b, lvl, ph[b]);
        tally_and_finish();
      end
    end
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    for (int a = 0; a < 12; a++) begin
      regr(a[4:0], (a == 3) ? 8'hff : 8'h00);
    end
    regr(5'h10, 8'h00);
    cmd(8'ha4);
    for (int i = 0; i < 8; i++) begin
      u_host_model.xfer(3'h2, (i % 2) ? 8'((i + 1) / 2) : 8'h00, d);
    end
    for (int i = 0; i < 8; i++) begin
      regr(5'(i + 4), (i % 2) ? 8'((i + 1) / 2) : 8'h00);
    end
    regw(5'h00, 8'h31);
    ev(1'b0, 16'h00ff, 1'b0);
    ev(1'b1, 16'h0401, 1'b0);
    regw(5'h00, 8'h07);
    ev(1'b0, 16'h00ff, 1'b0);
    ev(1'b1, 16'h0401, 1'b0);
    regw(5'h00, 8'h37);
    regw(5'h0c, 8'h11);
    ev(1'b0, 16'h0150, 1'b0);
    ev(1'b0, 16'h00ff, 1'b1);
    check("irq_out", 16'h0000, {15'h0, irq_out});
    ev(1'b1, 16'h02ff, 1'b1);
    regr(5'h13, 8'h30);
    cmd(8'he5);
    check("irq_oe", 16'h0001, {15'h0, irq_oe});
    cmd(8'he6);
    check("irq_oe", 16'h0000, {15'h0, irq_oe});
    ev(1'b0, 16'h0201, 1'b1);
    cmd(8'he7);
    check("irq_oe", 16'h0000, {15'h0, irq_oe});
    ev(1'b1, 16'h0401, 1'b1);
    repeat (3) @(posedge clk);
    #1;
    check("irq_oe", 16'h0001, {15'h0, irq_oe});
    cmd(8'he7);
    regw(5'h0c, 8'h04);
    ev(1'b1, 16'h0350, 1'b1);
    cmd(8'he7);
    ev(1'b0, 16'h0150, 1'b0);
    for (int i = 0; i < 5; i++) begin
      ev(1'b0, 16'h00ff, i == 4);
    end
    cmd(8'he7);
    regw(5'h00, 8'h00);
    regw(5'h02, 8'hff);
    regw(5'h01, 8'hff);
    regw(5'h03, 8'hfe);
    regw(5'h00, 8'h0f);
    wait_for(1, 1'b1);
    check("warm-up", 16'h0001, {15'h0, n >= S});
    wait_for(2, 1'b1);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check("wait length", 16'h0001, {15'h0, n >= 2 * S && n <= 2 * S + 2});
    regw(5'h0d, 8'h02);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    check("long wait", 16'h0001, {15'h0, n >= 24 * S && n <= 24 * S + 2});
    regw(5'h00, 8'h07);
    d = 8'h00;
    repeat (64) begin
      @(posedge clk);
      #1;
      d = d | {7'h0, ph[0]};
    end
    check("wait off", 16'h0000, {8'h00, d});
    regw(5'h00, 8'h00);
    wait_for(3, 1'b0);
    check("power off", 16'h0001, {15'h0, n <= 2});
    check("phases", 16'h0000, {12'h000, ph});
    tally_and_finish();
  end
endmodule
